// File: include/sos_defs.svh
`ifndef SOS_DEFS_SVH
`define SOS_DEFS_SVH

// ****************************************
// register word addresses
// ****************************************
`define SOS_ADDR_W 4
`define SOS_DATA_W 16
`define SOS_REG_RELAY_FUNC 4'h0
`define SOS_REG_RELAY_UPPER 4'h1
`define SOS_REG_RELAY_LOWER 4'h2
`define SOS_REG_AOUT_SRC 4'h3
`define SOS_REG_AOUT_FORMAT 4'h4
`define SOS_REG_OUT_UPPER 4'h5
`define SOS_REG_OUT_LOWER 4'h6
`define SOS_REG_RATED_CURRENT 4'h7
`define SOS_REG_MAX_FREQ 4'h8
`define SOS_REG_STATUS 4'h9
`define SOS_REG_AOUT_VALUE 4'ha

// ****************************************
// reset values
// ****************************************
`define SOS_RST_RELAY_FUNC 4'h1
`define SOS_RST_AOUT_SRC 4'h8
`define SOS_RST_AOUT_FORMAT 3'h0
`define SOS_RST_THRESHOLD 16'h0000
`define SOS_RST_RATED_CURRENT 16'h0100
`define SOS_RST_MAX_FREQ 16'h0100

// ****************************************
// status register fields
// ****************************************
`define SOS_STAT_RELAY 0
`define SOS_STAT_RELAY_LIMIT 1
`define SOS_STAT_OUT_LIMIT 2
`define SOS_STAT_STO_A 3
`define SOS_STAT_STO_B 4

// ****************************************
// codes and scaling
// ****************************************
`define SOS_FUNC_W 4
`define SOS_FMT_W 3
`define SOS_LIMIT_LO 4'h4
`define SOS_LIMIT_HI 4'h7
`define SOS_FULL_SCALE 16'hffff
`define SOS_RATED_POWER 16'h1000

`endif

// File: include/sos_pkg.sv
`default_nettype none

package sos_pkg;

  // status flags from the control core
  typedef struct packed {
    logic drive_enabled;
    logic powered;
    logic fault_present;
    logic at_target;
    logic fire_mode;
    logic maint_due;
    logic auto_mode;
    logic trip_present;
    logic safety_ok;
    logic tripped;
    logic fault_shown;
    logic operable;
  } sos_status_type;

  // measured quantities from the control core
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] setpoint;
    logic [15:0] speed;
    logic [15:0] current;
    logic [15:0] ain2;
    logic [15:0] power;
  } sos_meas_type;

  // output function codes
  typedef enum logic [3:0] {
    SOS_F_RUNNING = 4'h0,
    SOS_F_HEALTHY = 4'h1,
    SOS_F_AT_TARGET = 4'h2,
    SOS_F_FREQ_NZ = 4'h3,
    SOS_F_SPEED_LIM = 4'h4,
    SOS_F_CURR_LIM = 4'h5,
    SOS_F_RSVD6 = 4'h6,
    SOS_F_AIN2_LIM = 4'h7,
    SOS_F_SPEED = 4'h8,
    SOS_F_FIRE = 4'h9,
    SOS_F_MAINT = 4'ha,
    SOS_F_AVAIL = 4'hb,
    SOS_F_TRIPPED = 4'hc,
    SOS_F_STO_OK = 4'hd
  } sos_func_type;

endpackage

`default_nettype wire

// File: src/sos_hyst.sv
`default_nettype none

// ****************************************
// threshold comparator with hysteresis
// ****************************************
module sos_hyst #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic active_in,
  input wire logic [WIDTH-1:0] value_in,
  input wire logic [WIDTH-1:0] upper_in,
  input wire logic [WIDTH-1:0] lower_in,
  output var logic state_out
);

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_out <= 1'b0;
    end else if (!active_in) begin
      state_out <= 1'b0;
    end else if (value_in > upper_in) begin
      state_out <= 1'b1;
    end else if (value_in < lower_in) begin
      state_out <= 1'b0;
    end else begin
      state_out <= state_out;
    end
  end

endmodule

`default_nettype wire

// File: src/sos_top.sv
// Operation
// - limit output sets above upper threshold
// - limit output clears below lower threshold
// - hysteresis only for codes four to seven
// - source 9 current, full at twice rated
// - source 11 power, full at 1.5x rated
// - source 10 gives nothing
// - logic 1 energises relay, swaps contacts
// - code 0 active while drive running
// - code 1 active when powered, no fault
// - code 3 active when frequency above zero
// - code 4 speed limit with hysteresis
// - code 5 current limit with hysteresis
// - codes 6 and 8 do nothing
// - code 7 analog input two limit
// - code 9 active in emergency override
// - code 10 active when service due
// - code 11 auto, no trip, safety on
// - code 12 tripped and showing fault
// - code 13 both torque-off inputs present and core operable
// - code 2 active at set-point frequency
// - relay uses its own thresholds

`include "sos_defs.svh"

`default_nettype none

module sos_top #(
  parameter logic [15:0] RATED_POWER = `SOS_RATED_POWER
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [`SOS_ADDR_W-1:0] reg_addr_in,
  input wire logic [`SOS_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output var logic [`SOS_DATA_W-1:0] reg_rdata_out,
  input wire sos_pkg::sos_status_type status_in,
  input wire sos_pkg::sos_meas_type meas_in,
  input wire logic [1:0] safe_torque_off_input_in,
  output var logic relay_coil_out,
  output var logic relay_no_closed_out,
  output var logic relay_nc_closed_out,
  output var logic [15:0] analog_out_value_out,
  output var logic [`SOS_FMT_W-1:0] analog_out_two_format_out
);

  // ****************************************
  // scaling constants
  // ****************************************
  localparam logic [16:0] POWER_FS = 17'((32'(RATED_POWER) * 3) / 2);

  // ****************************************
  // registers and internal signals
  // ****************************************
  logic [3:0] relay_one_function_select;
  logic [15:0] relay_upper_threshold;
  logic [15:0] relay_lower_threshold;
  logic [3:0] analog_out_source_select;
  logic [`SOS_FMT_W-1:0] analog_out_two_format;
  logic [15:0] output_upper_threshold;
  logic [15:0] output_lower_threshold;
  logic [15:0] motor_rated_current_setting;
  logic [15:0] max_frequency_setting;
  logic [1:0] sto_meta;
  logic [1:0] sto_sync;
  logic relay_limit_state;
  logic out_limit_state;
  logic [15:0] relay_limit_value;
  logic [15:0] out_limit_value;
  logic relay_limit_active;
  logic out_limit_active;
  logic next_relay;
  logic [15:0] next_analog;
  logic [15:0] next_rdata;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic in_limit_range(input logic [3:0] code);
    in_limit_range = (code >= `SOS_LIMIT_LO) && (code <= `SOS_LIMIT_HI);
  endfunction

  function automatic logic [15:0] limit_signal(
    input logic [3:0] code,
    input sos_pkg::sos_meas_type m
  );
    case (code)
      sos_pkg::SOS_F_SPEED_LIM: limit_signal = m.speed;
      sos_pkg::SOS_F_CURR_LIM: limit_signal = m.current;
      sos_pkg::SOS_F_AIN2_LIM: limit_signal = m.ain2;
      default: limit_signal = 16'h0000;
    endcase
  endfunction

  function automatic logic status_decode(
    input logic [3:0] code,
    input sos_pkg::sos_status_type s,
    input sos_pkg::sos_meas_type m,
    input logic limit_state,
    input logic [1:0] safe_torque_off_input
  );
    case (code)
      sos_pkg::SOS_F_RUNNING: status_decode = s.drive_enabled;
      sos_pkg::SOS_F_HEALTHY: begin
        status_decode = s.powered && !s.fault_present;
      end
      sos_pkg::SOS_F_AT_TARGET: begin
        status_decode = (m.out_freq == m.setpoint);
      end
      sos_pkg::SOS_F_FREQ_NZ: status_decode = (m.out_freq != 16'h0000);
      sos_pkg::SOS_F_SPEED_LIM: status_decode = limit_state;
      sos_pkg::SOS_F_CURR_LIM: status_decode = limit_state;
      sos_pkg::SOS_F_RSVD6: status_decode = 1'b0;
      sos_pkg::SOS_F_AIN2_LIM: status_decode = limit_state;
      sos_pkg::SOS_F_SPEED: status_decode = 1'b0;
      sos_pkg::SOS_F_FIRE: status_decode = s.fire_mode;
      sos_pkg::SOS_F_MAINT: status_decode = s.maint_due;
      sos_pkg::SOS_F_AVAIL: begin
        status_decode = s.auto_mode && !s.trip_present && s.safety_ok;
      end
      sos_pkg::SOS_F_TRIPPED: begin
        status_decode = s.tripped && s.fault_shown;
      end
      sos_pkg::SOS_F_STO_OK: begin
        status_decode = (&safe_torque_off_input) && s.operable;
      end
      default: status_decode = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] scale_to_full(
    input logic [15:0] x,
    input logic [16:0] fs
  );
    logic [31:0] prod;
    logic [31:0] quot;
    prod = 32'(x) * 32'h0000_ffff;
    quot = 32'h0000_0000;
    if (fs == 17'h0_0000) begin
      scale_to_full = `SOS_FULL_SCALE;
    end else begin
      quot = prod / 32'(fs);
      if (quot > 32'h0000_ffff) begin
        scale_to_full = `SOS_FULL_SCALE;
      end else begin
        scale_to_full = quot[15:0];
      end
    end
  endfunction

  // ****************************************
  // torque-off input synchroniser
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sto_meta <= 2'h0;
      sto_sync <= 2'h0;
    end else begin
      sto_meta <= safe_torque_off_input_in;
      sto_sync <= sto_meta;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      relay_one_function_select <= `SOS_RST_RELAY_FUNC;
    end else if (reg_write_in && reg_addr_in == `SOS_REG_RELAY_FUNC) begin
      relay_one_function_select <= reg_wdata_in[3:0];
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      relay_upper_threshold <= `SOS_RST_THRESHOLD;
      relay_lower_threshold <= `SOS_RST_THRESHOLD;
    end else if (reg_write_in) begin
      if (reg_addr_in == `SOS_REG_RELAY_UPPER) begin
        relay_upper_threshold <= reg_wdata_in;
      end
      if (reg_addr_in == `SOS_REG_RELAY_LOWER) begin
        relay_lower_threshold <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      analog_out_source_select <= `SOS_RST_AOUT_SRC;
      analog_out_two_format <= `SOS_RST_AOUT_FORMAT;
    end else if (reg_write_in) begin
      if (reg_addr_in == `SOS_REG_AOUT_SRC) begin
        analog_out_source_select <= reg_wdata_in[3:0];
      end
      if (reg_addr_in == `SOS_REG_AOUT_FORMAT) begin
        analog_out_two_format <= reg_wdata_in[`SOS_FMT_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      output_upper_threshold <= `SOS_RST_THRESHOLD;
      output_lower_threshold <= `SOS_RST_THRESHOLD;
    end else if (reg_write_in) begin
      if (reg_addr_in == `SOS_REG_OUT_UPPER) begin
        output_upper_threshold <= reg_wdata_in;
      end
      if (reg_addr_in == `SOS_REG_OUT_LOWER) begin
        output_lower_threshold <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      motor_rated_current_setting <= `SOS_RST_RATED_CURRENT;
      max_frequency_setting <= `SOS_RST_MAX_FREQ;
    end else if (reg_write_in) begin
      if (reg_addr_in == `SOS_REG_RATED_CURRENT) begin
        motor_rated_current_setting <= reg_wdata_in;
      end
      if (reg_addr_in == `SOS_REG_MAX_FREQ) begin
        max_frequency_setting <= reg_wdata_in;
      end
    end
  end

  // ****************************************
  // limit comparators
  // ****************************************
  assign relay_limit_active = in_limit_range(relay_one_function_select);
  assign relay_limit_value = limit_signal(relay_one_function_select, meas_in);
  assign out_limit_active = in_limit_range(analog_out_source_select);
  assign out_limit_value = limit_signal(analog_out_source_select, meas_in);

  // relay compares against its own pair
  sos_hyst #(
    .WIDTH(16)
  ) u_relay_hyst (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .active_in(relay_limit_active),
    .value_in(relay_limit_value),
    .upper_in(relay_upper_threshold),
    .lower_in(relay_lower_threshold),
    .state_out(relay_limit_state)
  );

  sos_hyst #(
    .WIDTH(16)
  ) u_out_hyst (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .active_in(out_limit_active),
    .value_in(out_limit_value),
    .upper_in(output_upper_threshold),
    .lower_in(output_lower_threshold),
    .state_out(out_limit_state)
  );

  // ****************************************
  // relay function
  // ****************************************
  always_comb begin
    next_relay = status_decode(relay_one_function_select, status_in, meas_in,
                               relay_limit_state, sto_sync);
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      relay_coil_out <= 1'b0;
      relay_no_closed_out <= 1'b0;
      relay_nc_closed_out <= 1'b1;
    end else begin
      relay_coil_out <= next_relay;
      relay_no_closed_out <= next_relay;
      relay_nc_closed_out <= !next_relay;
    end
  end

  // ****************************************
  // analog output source
  // ****************************************
  always_comb begin
    next_analog = 16'h0000;
    case (analog_out_source_select)
      4'h8: begin
        next_analog = scale_to_full(meas_in.out_freq, {1'b0, max_frequency_setting});
      end
      4'h9: begin
        next_analog = scale_to_full(meas_in.current,
                                    {motor_rated_current_setting, 1'b0});
      end
      4'ha: next_analog = 16'h0000;
      4'hb: next_analog = scale_to_full(meas_in.power, POWER_FS);
      default: begin
        if (status_decode(analog_out_source_select, status_in, meas_in,
                          out_limit_state, sto_sync)) begin
          next_analog = `SOS_FULL_SCALE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      analog_out_value_out <= 16'h0000;
    end else begin
      analog_out_value_out <= next_analog;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      analog_out_two_format_out <= `SOS_RST_AOUT_FORMAT;
    end else begin
      analog_out_two_format_out <= analog_out_two_format;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr_in)
      `SOS_REG_RELAY_FUNC: next_rdata = {12'h000, relay_one_function_select};
      `SOS_REG_RELAY_UPPER: next_rdata = relay_upper_threshold;
      `SOS_REG_RELAY_LOWER: next_rdata = relay_lower_threshold;
      `SOS_REG_AOUT_SRC: next_rdata = {12'h000, analog_out_source_select};
      `SOS_REG_AOUT_FORMAT: begin
        next_rdata = {13'h0000, analog_out_two_format};
      end
      `SOS_REG_OUT_UPPER: next_rdata = output_upper_threshold;
      `SOS_REG_OUT_LOWER: next_rdata = output_lower_threshold;
      `SOS_REG_RATED_CURRENT: next_rdata = motor_rated_current_setting;
      `SOS_REG_MAX_FREQ: next_rdata = max_frequency_setting;
      `SOS_REG_STATUS: begin
        next_rdata[`SOS_STAT_RELAY] = relay_coil_out;
        next_rdata[`SOS_STAT_RELAY_LIMIT] = relay_limit_state;
        next_rdata[`SOS_STAT_OUT_LIMIT] = out_limit_state;
        next_rdata[`SOS_STAT_STO_A] = sto_sync[0];
        next_rdata[`SOS_STAT_STO_B] = sto_sync[1];
      end
      `SOS_REG_AOUT_VALUE: next_rdata = analog_out_value_out;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

// File: sim/sos_top_asserts.sv
`include "sos_defs.svh"
`default_nettype none

// ****************************************
// output selector checker
// ****************************************
module sos_top_asserts #(
  parameter logic [15:0] RATED_POWER = `SOS_RATED_POWER
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [`SOS_ADDR_W-1:0] reg_addr_in,
  input wire logic [`SOS_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [`SOS_DATA_W-1:0] reg_rdata_out,
  input wire sos_pkg::sos_status_type status_in,
  input wire sos_pkg::sos_meas_type meas_in,
  input wire logic [1:0] safe_torque_off_input_in,
  input wire logic relay_coil_out,
  input wire logic relay_no_closed_out,
  input wire logic relay_nc_closed_out,
  input wire logic [15:0] analog_out_value_out,
  input wire logic [`SOS_FMT_W-1:0] analog_out_two_format_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] func_q;
  logic [3:0] src_q;
  logic [15:0] up_q;
  logic [15:0] lo_q;
  logic [15:0] rated_q;
  logic [15:0] ana_q;
  logic [15:0] sel;
  logic direct_q;
  logic exp_q;
  logic lim;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  function automatic logic [15:0] scale(input logic [15:0] x, input logic [16:0] fs);
    logic [32:0] q;
    q = {17'h0_0000, x} * 33'h0_0000_ffff;
    if (fs == 17'h0_0000) begin
      return 16'hffff;
    end
    q = q / {16'h0000, fs};
    return (q > 33'h0_0000_ffff) ? 16'hffff : q[15:0];
  endfunction
  // shadow of the written settings
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      func_q <= `SOS_RST_RELAY_FUNC;
      src_q <= `SOS_RST_AOUT_SRC;
      up_q <= `SOS_RST_THRESHOLD;
      lo_q <= `SOS_RST_THRESHOLD;
      rated_q <= `SOS_RST_RATED_CURRENT;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        `SOS_REG_RELAY_FUNC: func_q <= reg_wdata_in[3:0];
        `SOS_REG_RELAY_UPPER: up_q <= reg_wdata_in;
        `SOS_REG_RELAY_LOWER: lo_q <= reg_wdata_in;
        `SOS_REG_AOUT_SRC: src_q <= reg_wdata_in[3:0];
        `SOS_REG_RATED_CURRENT: rated_q <= reg_wdata_in;
        default: ;
      endcase
    end
  end
  always_comb begin
    case (func_q)
      4'h4: sel = meas_in.speed;
      4'h7: sel = meas_in.ain2;
      default: sel = meas_in.current;
    endcase
  end
  assign lim = func_q inside {4'h4, 4'h5, 4'h7};
  // expected outputs one edge on
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      direct_q <= 1'b0;
      exp_q <= 1'b0;
      ana_q <= 16'h0000;
    end else begin
      direct_q <= func_q inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hc};
      case (func_q)
        4'h0: exp_q <= status_in.drive_enabled;
        4'h1: exp_q <= status_in.powered && !status_in.fault_present;
        4'h2: exp_q <= meas_in.out_freq == meas_in.setpoint;
        4'h3: exp_q <= meas_in.out_freq != 16'h0000;
        4'h9: exp_q <= status_in.fire_mode;
        4'ha: exp_q <= status_in.maint_due;
        4'hb: exp_q <= status_in.auto_mode && !status_in.trip_present && status_in.safety_ok;
        default: exp_q <= status_in.tripped && status_in.fault_shown;
      endcase
      ana_q <= (src_q == 4'h9) ? scale(meas_in.current, {rated_q, 1'b0}) :
        scale(meas_in.power, {1'b0, RATED_POWER} + {2'b00, RATED_POWER[15:1]});
    end
  end
  sequence s_over;
    lim && sel > up_q && sel >= lo_q ##1 lim;
  endsequence
  sequence s_under;
    lim && sel < lo_q && sel <= up_q ##1 lim;
  endsequence
  sequence s_between;
    lim && sel >= lo_q && sel <= up_q ##1 lim;
  endsequence
  a_contacts_follow_coil: assert property (
    relay_no_closed_out == relay_coil_out && relay_nc_closed_out == !relay_coil_out)
    else $error("relay contacts disagree with coil");
  a_direct_code_result: assert property (
    direct_q |-> relay_coil_out == exp_q) else $error("relay status code result wrong");
  a_reserved_code_off: assert property (
    func_q inside {4'h6, 4'h8, 4'he, 4'hf} |=> !relay_coil_out)
    else $error("reserved relay code energised coil");
  a_limit_sets_high: assert property (
    s_over |=> relay_coil_out) else $error("limit output did not set");
  a_limit_clears_low: assert property (
    s_under |=> !relay_coil_out) else $error("limit output did not clear");
  a_limit_holds_between: assert property (
    s_between |=> $stable(relay_coil_out)) else $error("limit output moved between");
  a_torque_off_ready: assert property (
    (func_q == 4'hd) [*3] |=> relay_coil_out ==
    (&$past(safe_torque_off_input_in, 3) && $past(status_in.operable)))
    else $error("torque-off status result wrong");
  a_analog_reserved_zero: assert property (
    src_q == 4'ha |=> analog_out_value_out == 16'h0000) else $error("reserved source nonzero");
  a_analog_current_scale: assert property (
    src_q == 4'h9 |=> analog_out_value_out == ana_q) else $error("current scaling wrong");
  a_analog_power_scale: assert property (
    src_q == 4'hb |=> analog_out_value_out == ana_q) else $error("power scaling wrong");
endmodule

bind sos_top sos_top_asserts #(.RATED_POWER(RATED_POWER)) chk_u (.sys_clk_in, .reset_in,
  .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .status_in,
  .meas_in, .safe_torque_off_input_in, .relay_coil_out, .relay_no_closed_out,
  .relay_nc_closed_out, .analog_out_value_out, .analog_out_two_format_out);

`default_nettype wire

// File: sim/sos_core_model.sv
`default_nettype none

// ****************************************
// control core status and measurements
// ****************************************
module sos_core_model (
  input wire logic sys_clk_in,
  output var sos_pkg::sos_status_type status_out,
  output var sos_pkg::sos_meas_type meas_out,
  output var logic [1:0] sto_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    status_out = '0;
    meas_out = '0;
    sto_out = 2'h0;
  end
  // new levels land on the next edge
  task automatic put(input sos_pkg::sos_status_type s, input sos_pkg::sos_meas_type m,
    input logic [1:0] t);
    @(posedge sys_clk_in);
    status_out <= s;
    meas_out <= m;
    sto_out <= t;
  endtask
endmodule

`default_nettype wire

// File: sim/tb_top.sv
`include "sos_defs.svh"
`default_nettype none

// ****************************************
// output selector testbench
// ****************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic [15:0] rdata;
  logic [15:0] ana;
  logic coil;
  logic no_c;
  logic nc_c;
  logic [2:0] fmt;
  sos_pkg::sos_status_type st = '0;
  sos_pkg::sos_status_type st_w;
  sos_pkg::sos_meas_type ms = '0;
  sos_pkg::sos_meas_type ms_w;
  logic [1:0] safe_torque_off_input = 2'h0;
  logic [1:0] sto_w;
  int mismatches = 0;
  int compares = 0;
  always #10 sys_clk_in = ~sys_clk_in;
  sos_core_model core_u (.sys_clk_in, .status_out(st_w), .meas_out(ms_w), .sto_out(sto_w));
  sos_top dut_u (.sys_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out(rdata), .status_in(st_w), .meas_in(ms_w),
    .safe_torque_off_input_in(sto_w), .relay_coil_out(coil), .relay_no_closed_out(no_c),
    .relay_nc_closed_out(nc_c), .analog_out_value_out(ana), .analog_out_two_format_out(fmt));
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_read_in <= 1'b0;
    #1;
    chk16(rdata, exp);
  endtask
  task automatic apply();
    core_u.put(st, ms, safe_torque_off_input);
    settle(5);
  endtask
  task automatic t_reset();
    chk1(nc_c, 1'b1);
    chk1(coil, 1'b0);
    chk1(no_c, 1'b0);
    rd(`SOS_REG_RELAY_FUNC, 16'h0001);
    rd(`SOS_REG_AOUT_SRC, 16'h0008);
    rd(4'hc, 16'h0000);
    wr(`SOS_REG_AOUT_FORMAT, 16'hfffd);
    settle(2);
    chk16({13'h0000, fmt}, 16'h0005);
    $display("test reset done");
  endtask
  task automatic t_direct();
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h9, 4'ha, 4'hb, 4'hc, 4'h2, 4'h3};
    logic [3:0] keys [6] = '{4'hb, 4'h9, 4'h7, 4'h6, 4'h4, 4'h1};
    logic [3:0] rsv [4] = '{4'h6, 4'h8, 4'he, 4'hf};
    for (int i = 0; i < 8; i++) begin
      wr(`SOS_REG_RELAY_FUNC, {12'h000, codes[i]});
      st = 12'hdef;
      ms.out_freq = 16'h0005;
      ms.setpoint = 16'h0005;
      apply();
      chk1(coil, 1'b1);
      chk1(no_c, 1'b1);
      chk1(nc_c, 1'b0);
      if (i < 6) begin
        st[keys[i]] = ~st[keys[i]];
      end else if (i == 6) begin
        ms.setpoint = 16'h0006;
      end else begin
        ms.out_freq = 16'h0000;
      end
      apply();
      chk1(coil, 1'b0);
      chk1(no_c, 1'b0);
      chk1(nc_c, 1'b1);
    end
    foreach (rsv[i]) begin
      wr(`SOS_REG_RELAY_FUNC, {12'h000, rsv[i]});
      st = 12'hfff;
      apply();
      chk1(coil, 1'b0);
    end
    $display("test direct codes done");
  endtask
  task automatic set_sel(input logic [3:0] c, input logic [15:0] v);
    case (c)
      4'h4: ms.speed = v;
      4'h5: ms.current = v;
      default: ms.ain2 = v;
    endcase
  endtask
  task automatic t_limit(input logic [3:0] c);
    logic [15:0] v [9] = '{16'h0065, 16'h0046, 16'h0064, 16'h0032, 16'h0031, 16'h0046,
      16'h0064, 16'h0065, 16'h03e9};
    logic e [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    ms = '{default: 16'h0200};
    wr(`SOS_REG_RELAY_FUNC, {12'h000, c});
    wr(`SOS_REG_AOUT_SRC, {12'h000, c});
    for (int i = 0; i < 9; i++) begin
      set_sel(c, v[i]);
      apply();
      chk1(coil, e[i]);
      chk16(ana, (i == 8) ? 16'hffff : 16'h0000);
    end
    st = '0;
    wr(`SOS_REG_RELAY_FUNC, 16'h0001);
    set_sel(c, 16'h0046);
    apply();
    wr(`SOS_REG_RELAY_FUNC, {12'h000, c});
    settle(5);
    chk1(coil, 1'b0);
    $display("test limit code done");
  endtask
  task automatic t_sto();
    wr(`SOS_REG_RELAY_FUNC, 16'h000d);
    st = '0;
    st.operable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      safe_torque_off_input = 2'(i);
      apply();
      chk1(coil, i == 3);
    end
    rd(`SOS_REG_STATUS, 16'h0019);
    st.operable = 1'b0;
    apply();
    chk1(coil, 1'b0);
    $display("test torque-off done");
  endtask
  task automatic t_analog();
    ms = '0;
    wr(`SOS_REG_AOUT_SRC, 16'h0009);
    ms.current = 16'h0100;
    apply();
    chk16(ana, 16'h7fff);
    ms.current = 16'h0400;
    apply();
    chk16(ana, 16'hffff);
    wr(`SOS_REG_RATED_CURRENT, 16'h0080);
    ms.current = 16'h0080;
    apply();
    chk16(ana, 16'h7fff);
    wr(`SOS_REG_AOUT_SRC, 16'h000b);
    ms.power = 16'h0c00;
    apply();
    chk16(ana, 16'h7fff);
    ms.power = 16'h1800;
    apply();
    chk16(ana, 16'hffff);
    wr(`SOS_REG_AOUT_SRC, 16'h000a);
    apply();
    chk16(ana, 16'h0000);
    $display("test analog done");
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_direct();
    wr(`SOS_REG_RELAY_UPPER, 16'h0064);
    wr(`SOS_REG_RELAY_LOWER, 16'h0032);
    wr(`SOS_REG_OUT_UPPER, 16'h03e8);
    wr(`SOS_REG_OUT_LOWER, 16'h0384);
    t_limit(4'h4);
    t_limit(4'h5);
    t_limit(4'h7);
    t_sto();
    t_analog();
    end_of_test();
  end
  initial begin
    #200us;
    mismatches++;
    end_of_test();
  end
endmodule

`default_nettype wire
